// >>> design/alc_core.sv
// Automatic level control: AHB-Lite registers, level detectors and per-channel gain loop
//
// Contract
// - Noise gate works only while the gate-enable bit is high.
// - Gate threshold comes from the three low bits of the gate register.
// - Gate asserts when input-referred level falls below the threshold.
// - While gated, gain is frozen instead of rising toward target.
// - Gate acts only with level control enabled and in normal mode.
// - One shared parameter set for both channels; each channel enabled separately.
// - Enable field: 00 off, 01 right, 10 left, 11 both.
// - A disabled channel PGA keeps the last gain the loop gave it.
// - Lower gain bound from bits 2:0, -12dB up in 6dB steps.
// - Upper gain bound from bits 5:3, -6.75dB up in 6dB steps.
// - Target level from bits 3:0, 1.5dB steps, reset -6dBFS.
// - Hold time from bits 7:4, doubling per code, saturating at 1024ms.
// - Attack step time doubles per code, faster table in limiter mode.
// - Decay step time doubles per code, faster table in limiter mode.
// - Limiter mode when its bit is high and any channel is enabled.
// - Limiter never raises gain above the gain held on limiter entry.
// - Live left and right gain readable in their readout registers.
// - Live left-channel peak-to-peak and peak levels readable in readout registers.
// - Stop reducing at 1.5dB below target; raise only 1.5dB below.
// - Output must stay below target for the whole hold time first.
// - Above 87.5% full scale, reduce gain at the fastest attack rate.
`timescale 1ns/100ps
`include "alc_regs.svh"

module alc_core
    import alc_pkg::*;
#(
    parameter int ATK_NORM_CYC = `ALC_ATK_NORM_NS / `ALC_CLK_NS,
    parameter int ATK_LIM_CYC = `ALC_ATK_LIM_NS / `ALC_CLK_NS,
    parameter int DCY_NORM_CYC = `ALC_DCY_NORM_NS / `ALC_CLK_NS,
    parameter int DCY_LIM_CYC = `ALC_DCY_LIM_NS / `ALC_CLK_NS,
    parameter int HOLD_UNIT_CYC = `ALC_HOLD_UNIT_NS / `ALC_CLK_NS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire alc_sample_t [1:0] adc_sample,
    input wire logic [1:0] mic_boost,
    input wire logic [1:0] pga_enable,
    output alc_gain_t [1:0] pga_gain
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Target level as the top 12 bits of a 24-bit magnitude
    function automatic logic [11:0] target_lin(input logic [3:0] code);
        case (code)
            4'h0: target_lin = 12'h099;
            4'h1: target_lin = 12'h0b6;
            4'h2: target_lin = 12'h0d9;
            4'h3: target_lin = 12'h102;
            4'h4: target_lin = 12'h132;
            4'h5: target_lin = 12'h16c;
            4'h6: target_lin = 12'h1b1;
            4'h7: target_lin = 12'h202;
            4'h8: target_lin = 12'h263;
            4'h9: target_lin = 12'h2d7;
            4'ha: target_lin = 12'h360;
            4'hb: target_lin = 12'h402;
            4'hc: target_lin = 12'h4c4;
            4'hd: target_lin = 12'h5aa;
            default: target_lin = 12'h6bb;
        endcase
    endfunction
    // Position of the leading one, a coarse log2 of the level
    function automatic logic [4:0] msb_pos(input logic [23:0] v);
        msb_pos = 5'h00;
        for (int b = 0; b < 24; b++) begin
            if (v[b]) begin
                msb_pos = 5'(b);
            end
        end
    endfunction
    // Saturate a doubling-time code
    function automatic logic [3:0] sat_code(input logic [3:0] code);
        sat_code = (code > `ALC_TIME_CODE_MAX) ? `ALC_TIME_CODE_MAX : code;
    endfunction
    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic [8:0] reg_limits;
    logic [8:0] reg_target;
    logic [8:0] reg_mode;
    logic [8:0] reg_gate;
    logic avg_sel;
    logic wr_pend;
    logic rd_pend;
    logic ap_ok;
    logic [8:0] ap_idx;
    logic [8:0] rd_mux;
    logic [23:0] peak_rd [2];
    logic [24:0] p2p_rd [2];
    // Address phase decode; reads take one wait state so writes just before are seen
    wire take = hsel & hready & htrans[1];
    wire hi_zero = (haddr[31:11] == 21'h000000);
    wire wr_go = wr_pend & ap_ok;
    wire wr_limits = wr_go & (ap_idx == `ALC_IDX_LIMITS);
    wire wr_target = wr_go & (ap_idx == `ALC_IDX_TARGET);
    wire wr_mode = wr_go & (ap_idx == `ALC_IDX_MODE);
    wire wr_gate = wr_go & (ap_idx == `ALC_IDX_GATE);
    wire wr_opt = wr_go & (ap_idx == `ALC_IDX_LEFT_RD);
    assign hreadyout = ~rd_pend;
    assign hresp = 1'b0;
    // Bus phase tracking
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ap_ok <= 1'b0;
            ap_idx <= 9'h000;
        end else begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            if (take) begin
                ap_ok <= hi_zero;
                ap_idx <= haddr[10:2];
            end
        end
    end
    // Control registers, written in the data phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_limits <= `ALC_RST_LIMITS;
            reg_target <= `ALC_RST_TARGET;
            reg_mode <= `ALC_RST_MODE;
            reg_gate <= `ALC_RST_GATE;
            avg_sel <= 1'b0;
        end else begin
            if (wr_limits) reg_limits <= hwdata[8:0];
            if (wr_target) reg_target <= hwdata[8:0];
            if (wr_mode) reg_mode <= hwdata[8:0];
            if (wr_gate) reg_gate <= hwdata[8:0];
            if (wr_opt) avg_sel <= hwdata[`ALC_F_AVG_SEL];
        end
    end
    // Read selection; unmapped addresses read zero
    always_comb begin
        if (!ap_ok) begin
            rd_mux = 9'h000;
        end else if (ap_idx == `ALC_IDX_LIMITS) begin
            rd_mux = reg_limits;
        end else if (ap_idx == `ALC_IDX_TARGET) begin
            rd_mux = reg_target;
        end else if (ap_idx == `ALC_IDX_MODE) begin
            rd_mux = reg_mode;
        end else if (ap_idx == `ALC_IDX_GATE) begin
            rd_mux = reg_gate;
        end else if (ap_idx == `ALC_IDX_LEFT_RD) begin
            rd_mux = {avg_sel, 2'b00, pga_gain[1]};
        end else if (ap_idx == `ALC_IDX_RIGHT_RD) begin
            rd_mux = {3'b000, pga_gain[0]};
        end else if (ap_idx == `ALC_IDX_P2P_RD) begin
            rd_mux = p2p_rd[1][`ALC_P2P_RD];
        end else if (ap_idx == `ALC_IDX_PEAK_RD) begin
            rd_mux = peak_rd[1][`ALC_PEAK_RD];
        end else begin
            rd_mux = 9'h000;
        end
    end
    // Read data register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            hrdata <= {23'h000000, rd_mux};
        end
    end
    // ****************************************************************
    // Shared configuration and mode
    // ****************************************************************
    alc_cfg_t cfg;
    logic lim_prev;
    // One parameter set serves both channels
    assign cfg.en = reg_limits[`ALC_F_EN];
    assign cfg.min_k = reg_limits[`ALC_F_MIN];
    assign cfg.max_k = reg_limits[`ALC_F_MAX];
    assign cfg.target = reg_target[`ALC_F_TARGET];
    assign cfg.hold = reg_target[`ALC_F_HOLD];
    assign cfg.attack = reg_mode[`ALC_F_ATK];
    assign cfg.decay = reg_mode[`ALC_F_DCY];
    assign cfg.limiter = reg_mode[`ALC_F_LIM];
    assign cfg.gate_en = reg_gate[`ALC_F_GATE_EN];
    assign cfg.gate_thr = reg_gate[`ALC_F_GATE_THR];
    assign cfg.avg_sel = avg_sel;
    // Limiter mode and its entry moment
    wire lim_active = cfg.limiter & (cfg.en != 2'b00);
    wire lim_rise = lim_active & ~lim_prev;
    // Step periods; limiter uses the faster tables
    wire [27:0] atk_p = (lim_active ? 28'(ATK_LIM_CYC) : 28'(ATK_NORM_CYC)) << sat_code(cfg.attack);
    wire [27:0] dcy_p = (lim_active ? 28'(DCY_LIM_CYC) : 28'(DCY_NORM_CYC)) << sat_code(cfg.decay);
    wire [27:0] hold_p = (cfg.hold == 4'h0) ? 28'h0000000 : 28'(HOLD_UNIT_CYC) << sat_code(cfg.hold);
    wire [27:0] emg_p = 28'(ATK_LIM_CYC);
    wire [11:0] tgt = target_lin(cfg.target);
    wire [11:0] low_thr = tgt - (tgt >> 3) - (tgt >> 5);
    wire [5:0] floor_g = {cfg.min_k, 3'b000};
    // Limiter entry tracker
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lim_prev <= 1'b0;
        end else begin
            lim_prev <= lim_active;
        end
    end
    // ****************************************************************
    // Per-channel detectors and gain loop (0 right, 1 left)
    // ****************************************************************
    for (genvar i = 0; i < 2; i++) begin : g_ch
        alc_state_t state;
        alc_state_t next_state;
        logic [27:0] cnt;
        logic [27:0] next_cnt;
        logic [5:0] gain;
        logic [5:0] step_gain;
        logic [5:0] cap;
        logic [23:0] peak;
        logic [23:0] inst;
        logic signed [23:0] hi;
        logic signed [23:0] lo;
        // Sample magnitude and decaying detectors
        wire signed [23:0] smp = adc_sample[i].data;
        wire [23:0] mag = smp[23] ? (~smp + 24'h000001) : smp;
        wire [23:0] peak_dec = peak - (peak >> `ALC_PEAK_DECAY_SHIFT);
        wire signed [23:0] hi_dec = hi - (hi >>> `ALC_PEAK_DECAY_SHIFT);
        wire signed [23:0] lo_dec = lo - (lo >>> `ALC_PEAK_DECAY_SHIFT);
        wire [24:0] p2p = {hi[23], hi} - {lo[23], lo};
        wire [23:0] level = cfg.avg_sel ? p2p[24:1] : peak;
        assign peak_rd[i] = peak;
        assign p2p_rd[i] = p2p;
        // Level decisions against the target
        wire [11:0] lvl = level[`ALC_LVL_CMP];
        wire over = lvl > tgt;
        wire below = lvl < tgt;
        wire low = lvl < low_thr;
        wire emerg = inst >= `ALC_EMERG_MAG;
        wire active = cfg.en[i] & pga_enable[i];
        // Input-referred level against the gate threshold, in 0.75dB units
        wire [9:0] lhs = {2'b00, msb_pos(peak), 3'b000} + `ALC_GATE_GAIN_OFS;
        wire [9:0] boost_u = mic_boost[i] ? `ALC_BOOST_UNITS : 10'h000;
        wire [9:0] rhs = `ALC_GATE_BASE - {4'h0, cfg.gate_thr, 3'b000} + {4'h0, gain} + boost_u;
        wire gated = cfg.gate_en & ~lim_active & (lhs < rhs);
        // Gain ceiling: entry gain in limiter mode, upper bound otherwise
        wire [5:0] ceil_g = lim_active ? (lim_rise ? gain : cap) : {cfg.max_k, 3'b111};
        wire [5:0] clip_hi = (step_gain > ceil_g) ? ceil_g : step_gain;
        wire [5:0] next_gain = ~active ? gain : ((clip_hi < floor_g) ? floor_g : clip_hi);
        // Loop decisions: emergency first, then attack, hold and decay
        always_comb begin
            next_state = state;
            next_cnt = cnt;
            step_gain = gain;
            if (!active) begin
                next_state = ALC_ST_STEADY;
                next_cnt = 28'h0000000;
            end else if (emerg && state != ALC_ST_EMERG) begin
                next_state = ALC_ST_EMERG;
                next_cnt = emg_p;
            end else begin
                case (state)
                    ALC_ST_STEADY: begin
                        if (over) begin
                            next_state = ALC_ST_ATTACK;
                            next_cnt = atk_p;
                        end else if (low && !gated && gain < ceil_g) begin
                            next_state = ALC_ST_HOLD;
                            next_cnt = hold_p;
                        end
                    end
                    ALC_ST_ATTACK: begin
                        if (low) begin
                            next_state = ALC_ST_STEADY;
                        end else if (cnt == 28'h0000000) begin
                            step_gain = (gain > floor_g) ? gain - 6'h01 : gain;
                            next_cnt = atk_p;
                        end else begin
                            next_cnt = cnt - 28'h0000001;
                        end
                    end
                    ALC_ST_EMERG: begin
                        if (!emerg) begin
                            next_state = over ? ALC_ST_ATTACK : ALC_ST_STEADY;
                            next_cnt = atk_p;
                        end else if (cnt == 28'h0000000) begin
                            step_gain = (gain > floor_g) ? gain - 6'h01 : gain;
                            next_cnt = emg_p;
                        end else begin
                            next_cnt = cnt - 28'h0000001;
                        end
                    end
                    ALC_ST_HOLD: begin
                        if (!below || gated) begin
                            next_state = ALC_ST_STEADY;
                        end else if (cnt == 28'h0000000) begin
                            next_state = ALC_ST_DECAY;
                            next_cnt = dcy_p;
                        end else begin
                            next_cnt = cnt - 28'h0000001;
                        end
                    end
                    ALC_ST_DECAY: begin
                        if (over) begin
                            next_state = ALC_ST_ATTACK;
                            next_cnt = atk_p;
                        end else if (!low || gated) begin
                            next_state = ALC_ST_STEADY;
                        end else if (cnt == 28'h0000000) begin
                            step_gain = (gain < ceil_g) ? gain + 6'h01 : gain;
                            next_cnt = dcy_p;
                        end else begin
                            next_cnt = cnt - 28'h0000001;
                        end
                    end
                    default: begin
                        next_state = ALC_ST_STEADY;
                    end
                endcase
            end
        end
        // Loop state and gain
        always_ff @(posedge core_clk) begin
            if (rst) begin
                state <= ALC_ST_STEADY;
                cnt <= 28'h0000000;
                gain <= `ALC_GAIN_RST;
                cap <= `ALC_GAIN_RST;
            end else begin
                state <= next_state;
                cnt <= next_cnt;
                gain <= next_gain;
                if (lim_rise) cap <= gain;
            end
        end
        // Detectors update on each decimated sample
        always_ff @(posedge core_clk) begin
            if (rst) begin
                peak <= 24'h000000;
                inst <= 24'h000000;
                hi <= 24'sh000000;
                lo <= 24'sh000000;
            end else if (adc_sample[i].valid) begin
                peak <= (mag > peak_dec) ? mag : peak_dec;
                inst <= mag;
                hi <= (smp > hi_dec) ? smp : hi_dec;
                lo <= (smp < lo_dec) ? smp : lo_dec;
            end
        end

        assign pga_gain[i] = gain;
    end

endmodule

// >>> design/alc_regs.svh
// Register indices, field positions, reset values and timing figures of the level control
`ifndef ALC_REGS_SVH
`define ALC_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ALC_IDX_LIMITS 9'h020
`define ALC_IDX_TARGET 9'h021
`define ALC_IDX_MODE 9'h022
`define ALC_IDX_GATE 9'h023
`define ALC_IDX_LEFT_RD 9'h046
`define ALC_IDX_RIGHT_RD 9'h047
`define ALC_IDX_P2P_RD 9'h04c
`define ALC_IDX_PEAK_RD 9'h04d

// ****************************************************************
// Field positions
// ****************************************************************
`define ALC_F_MIN 2:0
`define ALC_F_MAX 5:3
`define ALC_F_EN 8:7
`define ALC_F_TARGET 3:0
`define ALC_F_HOLD 7:4
`define ALC_F_ATK 3:0
`define ALC_F_DCY 7:4
`define ALC_F_LIM 8
`define ALC_F_GATE_THR 2:0
`define ALC_F_GATE_EN 3
`define ALC_F_AVG_SEL 8
`define ALC_F_GAIN_RD 5:0
`define ALC_PEAK_RD 23:15
`define ALC_P2P_RD 24:16
`define ALC_LVL_CMP 23:12

// ****************************************************************
// Reset values
// ****************************************************************
`define ALC_RST_LIMITS 9'h038
`define ALC_RST_TARGET 9'h00b
`define ALC_RST_MODE 9'h032
`define ALC_RST_GATE 9'h000
`define ALC_GAIN_RST 6'h10

// ****************************************************************
// Timing and level figures
// ****************************************************************
`define ALC_CLK_NS 10
`define ALC_ATK_NORM_NS 125000
`define ALC_ATK_LIM_NS 31000
`define ALC_DCY_NORM_NS 500000
`define ALC_DCY_LIM_NS 125000
`define ALC_HOLD_UNIT_NS 1000000
`define ALC_TIME_CODE_MAX 4'ha
`define ALC_PEAK_DECAY_SHIFT 8
`define ALC_EMERG_MAG 24'h700000
`define ALC_GATE_BASE 10'h084
`define ALC_GATE_GAIN_OFS 10'h010
`define ALC_BOOST_UNITS 10'h01b

`endif

// >>> design/alc_pkg.sv
// Types shared by the level control design
package alc_pkg;

    typedef enum logic [2:0] {
        ALC_ST_STEADY,
        ALC_ST_ATTACK,
        ALC_ST_EMERG,
        ALC_ST_HOLD,
        ALC_ST_DECAY
    } alc_state_t;

    typedef logic [5:0] alc_gain_t;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } alc_sample_t;

    typedef struct packed {
        logic [1:0] en;
        logic [2:0] min_k;
        logic [2:0] max_k;
        logic [3:0] target;
        logic [3:0] hold;
        logic [3:0] attack;
        logic [3:0] decay;
        logic limiter;
        logic gate_en;
        logic [2:0] gate_thr;
        logic avg_sel;
    } alc_cfg_t;

endpackage

// >>> tb/alc_core_monitor.sv
// Checker for bus timing and gain stepping of the level control
`timescale 1ns/100ps
module alc_core_monitor
    import alc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [1:0] pga_enable,
    input wire alc_gain_t [1:0] pga_gain
);
    // ****
    // Properties
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Accepted transfers
    wire rd_taken = hsel && hready && htrans[1] && !hwrite;
    wire wr_taken = hsel && hready && htrans[1] && hwrite;
    property p_read_wait;
        rd_taken |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    property p_write_nowait;
        wr_taken |=> hreadyout;
    endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    property p_resp_okay;
        hresp == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
    property p_rdata_upper;
        hreadyout |-> hrdata[31:9] == 23'h0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
    property p_step_spacing;
        $changed(pga_gain[0]) |=> $stable(pga_gain[0]);
    endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("gain stepped twice in a row");
    property p_step_size;
        $changed(pga_gain[1]) |-> (pga_gain[1] == $past(pga_gain[1]) + 6'h1) ||
            (pga_gain[1] == $past(pga_gain[1]) - 6'h1);
    endproperty
    a_step_size: assert property (p_step_size) else $error("gain step larger than one code");
    property p_frozen_right;
        !pga_enable[0] && !$past(pga_enable[0]) |-> $stable(pga_gain[0]);
    endproperty
    a_frozen_right: assert property (p_frozen_right) else $error("right gain moved while off");
    property p_frozen_left;
        !pga_enable[1] ##1 !pga_enable[1] |-> $stable(pga_gain[1]);
    endproperty
    a_frozen_left: assert property (p_frozen_left) else $error("left gain moved while off");
    c_read: cover property (rd_taken ##2 hreadyout);
    c_step: cover property ($changed(pga_gain[0]));
    c_frozen: cover property (!pga_enable[1] ##1 !pga_enable[1]);
endmodule
bind alc_core alc_core_monitor u_monitor (.core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pga_enable(pga_enable), .pga_gain(pga_gain));

// >>> tb/alc_pga_model.sv
// Behavioural amplifier and converter that feed samples back to the level control
`timescale 1ns/100ps
module alc_pga_model
    import alc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [23:0] amp,
    input wire alc_gain_t [1:0] pga_gain,
    output alc_sample_t [1:0] adc_sample
);
    logic [1:0] cnt;
    // Gain of about 6dB per eight codes, unity at code 0x10, clipped at full scale
    function automatic logic [23:0] sample(input logic [23:0] a, input alc_gain_t g, input logic neg);
        logic [31:0] s;
        s = ({8'h0, a} << g[5:3]) >> 2;
        s = (s > 32'h7fffff) ? 32'h7fffff : s;
        return neg ? -s[23:0] : s[23:0];
    endfunction
    // A sample every other cycle; the data lines toggle between samples
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 2'h0;
            adc_sample <= '0;
        end else begin
            cnt <= cnt + 2'h1;
            for (int c = 0; c < 2; c++) begin
                adc_sample[c].valid <= cnt[0];
                adc_sample[c].data <= cnt[0] ? sample(amp, pga_gain[c], cnt[1]) : ~adc_sample[c].data;
            end
        end
    end
endmodule

// >>> tb/automatic_level_control_tb.sv
// Self-checking bench for the level control
`timescale 1ns/100ps
module automatic_level_control_tb;
    import alc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic [1:0] mic_boost = 2'h0;
    logic [1:0] pga_enable = 2'h3;
    logic [23:0] amp = 24'h0;
    logic [23:0] base = 24'h0;
    logic [31:0] rnd = 32'h00017326;
    logic rd_phase = 1'b0;
    logic [10:0] notes[$];
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    alc_sample_t [1:0] adc_sample;
    alc_gain_t [1:0] pga_gain;
    int n_mismatch = 0;
    int n_checks = 0;
    // ****
    // Design, partner and clock
    // ****
    alc_core #(.ATK_NORM_CYC(4), .ATK_LIM_CYC(2), .DCY_NORM_CYC(8), .DCY_LIM_CYC(4), .HOLD_UNIT_CYC(16)) DUT (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .adc_sample(adc_sample), .mic_boost(mic_boost), .pga_enable(pga_enable),
        .pga_gain(pga_gain));
    alc_pga_model u_pga (.core_clk(core_clk), .rst(rst), .amp(amp), .pga_gain(pga_gain), .adc_sample(adc_sample));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ****
    // Tasks
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Single AHB transfer: address phase, then data phase, each held until ready
    task xfer(input logic [31:0] a, input logic w, input logic [8:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        @(posedge core_clk iff hreadyout);
        htrans <= 2'h0;
        hwdata <= {23'h0, d};
        @(posedge core_clk iff hreadyout);
    endtask
    task wr(input logic [31:0] a, input logic [8:0] d);
        xfer(a, 1'b1, d);
    endtask
    // Kind 0 exact, 1 at most, 2 at least
    task rd(input logic [31:0] a, input logic [1:0] k, input logic [8:0] e);
        notes.push_back({k, e});
        xfer(a, 1'b0, 9'h0);
    endtask
    // Random jitter on level and boost
    always @(posedge core_clk) begin
        rnd <= lfsr(rnd);
        mic_boost <= rnd[1:0];
        amp <= base | {16'h0, rnd[7:0]};
    end
    // Read data watcher compares against the oldest note
    always @(posedge core_clk) begin
        logic [10:0] n;
        if (rd_phase && hreadyout && notes.size() > 0) begin
            n = notes.pop_front();
            case (n[10:9])
                2'd0: check(hrdata[8:0], n[8:0]);
                2'd1: check((hrdata[8:0] > n[8:0]) ? hrdata[8:0] : n[8:0], n[8:0]);
                default: check((hrdata[8:0] < n[8:0]) ? hrdata[8:0] : n[8:0], n[8:0]);
            endcase
        end
        if (hreadyout) rd_phase = hsel && htrans[1] && !hwrite;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(32'h80, 2'd0, 9'h038);
        rd(32'h84, 2'd0, 9'h00b);
        rd(32'h88, 2'd0, 9'h032);
        rd(32'h8c, 2'd0, 9'h000);
        rd(32'h118, 2'd0, 9'h010);
        wr(32'h11c, 9'h1ff);
        rd(32'h11c, 2'd0, 9'h010);
        rd(32'h800, 2'd0, 9'h000);
        // Loud input, right channel only
        base <= 24'h600000;
        wr(32'h80, 9'h0b8);
        repeat (600) @(posedge core_clk);
        rd(32'h11c, 2'd1, 9'h00f);
        rd(32'h118, 2'd0, 9'h010);
        rd(32'h134, 2'd0, 9'h0c0);
        rd(32'h130, 2'd2, 9'h0bf);
        // Clipping input, both channels, floor at code 8
        base <= 24'h7f0000;
        wr(32'h80, 9'h1b9);
        repeat (3000) @(posedge core_clk);
        rd(32'h118, 2'h0, 9'h008);
        rd(32'h11c, 2'd2, 9'h008);
        // Quiet input in limiter mode, left amplifier off
        base <= 24'h0;
        pga_enable <= 2'b01;
        wr(32'h88, 9'h132);
        repeat (6000) @(posedge core_clk);
        rd(32'h118, 2'h0, 9'h008);
        rd(32'h11c, 2'd1, 9'h010);
        // Normal mode with the gate on holds gain
        pga_enable <= 2'b11;
        wr(32'h88, 9'h032);
        wr(32'h8c, 9'h008);
        repeat (2000) @(posedge core_clk);
        rd(32'h118, 2'h0, 9'h008);
        // Gate off: gain rises, disabled right side stays
        wr(32'h8c, 9'h000);
        pga_enable <= 2'b10;
        repeat (3000) @(posedge core_clk);
        rd(32'h118, 2'd2, 9'h011);
        rd(32'h11c, 2'd1, 9'h010);
        end_of_test();
    end
    // Watchdog against a hung transfer
    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog timeout", $time);
        end_of_test();
    end
endmodule
